// >>> src/fwsp_pkg.sv
package fwsp_pkg;
  // command addresses and codes, low byte of data only
  localparam logic [19:0] FWSP_ADDR_UNLOCK1 = 20'h05555;
  localparam logic [19:0] FWSP_ADDR_UNLOCK2 = 20'h02AAA;
  localparam logic [7:0] FWSP_CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FWSP_CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] FWSP_CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] FWSP_CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FWSP_CODE_SECTOR = 8'h30;
  localparam logic [7:0] FWSP_CODE_BLOCK = 8'h50;
  localparam logic [7:0] FWSP_CODE_CHIP = 8'h10;
  localparam logic [7:0] FWSP_CODE_ID_ENTRY = 8'h90;
  localparam logic [7:0] FWSP_CODE_CFI_ENTRY = 8'h98;
  localparam logic [7:0] FWSP_CODE_EXIT = 8'hF0;
  // sector and block field positions
  localparam int FWSP_SECTOR_LSB = 11;
  localparam int FWSP_BLOCK_LSB = 15;
  // status bit positions
  localparam int FWSP_POLL_BIT = 7;
  localparam int FWSP_TOGGLE_BIT = 6;
  // identification word addresses
  localparam logic [19:0] FWSP_ADDR_MFR = 20'h00000;
  localparam logic [19:0] FWSP_ADDR_DEV = 20'h00001;
  // strobe timing: phases of a bus cycle
  localparam int FWSP_CLK_NS = 20;
  localparam int FWSP_GLITCH_NS = 5;
  // low pulse lasts at least glitch time, rounded up, min four
  localparam int FWSP_STROBE_CYC_RAW =
    (FWSP_GLITCH_NS + FWSP_CLK_NS - 1) / FWSP_CLK_NS;
  localparam int FWSP_STROBE_CYC =
    (FWSP_STROBE_CYC_RAW < 4) ? 4 : FWSP_STROBE_CYC_RAW;
  localparam logic [3:0] FWSP_PHASE_LAST = 4'(FWSP_STROBE_CYC - 1);
  // operation codes on the user port
  typedef enum logic [2:0] {
    FWSP_OP_READ, FWSP_OP_PROGRAM, FWSP_OP_SECTOR, FWSP_OP_BLOCK,
    FWSP_OP_CHIP, FWSP_OP_ID, FWSP_OP_CFI, FWSP_OP_EXIT
  } fwsp_op_e;
endpackage : fwsp_pkg

// >>> src/fwsp_bus_cycle.sv
`timescale 1ns/10ps
// one strobe cycle on the flash pins, write or read
module fwsp_bus_cycle
  import fwsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] a,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i
);
  logic [3:0] ph_reg, ph_next; // phase counter
  logic busy_reg, busy_next; // cycle running
  logic wr_reg, wr_next;
  logic [15:0] rd_reg, rd_next;
  logic [15:0] s1_reg, s2_reg; // pin synchroniser

  // next-state of the strobe sequencer
  always_comb begin
    ph_next = ph_reg;
    busy_next = busy_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (!busy_reg && start) begin
      busy_next = 1'b1;
      ph_next = 4'h0;
      wr_next = wr;
    end else if (busy_reg) begin
      ph_next = ph_reg + 4'h1;
      if (ph_reg == FWSP_PHASE_LAST + 4'h3) begin
        busy_next = 1'b0; // two sync stages then sample
        rd_next = s2_reg;
      end
    end
  end

  // registers; address held, data held through strobe rise
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_reg <= 4'h0;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 16'h0000;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      a <= 20'h00000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      done <= 1'b0;
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
    end else begin
      ph_reg <= ph_next;
      busy_reg <= busy_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      s1_reg <= dq_i;
      s2_reg <= s1_reg;
      done <= busy_reg && !busy_next;
      if (!busy_reg && start) begin
        a <= addr; // address set on the same edge as the strobes fall
        dq_o <= wdata;
        dq_oe <= wr; // never drive while reading
        ce_n <= 1'b0; // select device
        oe_n <= wr; // output gate high for writes
        we_n <= !wr; // full width low pulse, no glitch
      end else if (busy_reg && ph_reg == FWSP_PHASE_LAST) begin
        we_n <= 1'b1; // data taken on this rise
      end else if (busy_reg && !busy_next) begin
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        dq_oe <= 1'b0;
      end
    end
  end
  assign rdata = rd_reg;

  a_strobe_width: assert property (@(posedge clk) disable iff (rst)
    $fell(we_n) |-> !we_n [*4])
    else $error("write strobe too short");
  a_no_contend: assert property (@(posedge clk) disable iff (rst)
    dq_oe |-> oe_n)
    else $error("bus driven while output gate low");
endmodule : fwsp_bus_cycle

// >>> src/fwsp_host.sv
`timescale 1ns/10ps
// Functional notes
// - program needs three unlock cycles first
// - erase needs full six cycles
// - 98H at 5555H enters query mode
// - exit command leaves query mode
// - exit command leaves ID mode
// - address on fall, data on rise
// - last erase code picks erase kind
module fwsp_host
  import fwsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user command port
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic power_low,
  output logic ready,
  output logic done,
  output logic [15:0] rdata,
  // flash pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] a,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i
);
  typedef enum logic [2:0] {
    FWSP_IDLE, FWSP_CMD, FWSP_POLL1, FWSP_POLL2, FWSP_READ, FWSP_FIN
  } fwsp_state_e;
  fwsp_state_e st_reg, st_next; // main sequencer
  logic [2:0] step_reg, step_next; // command cycle index
  logic [2:0] nstep_reg, nstep_next; // cycles in this command
  logic [2:0] op_reg, op_next;
  logic [19:0] adr_reg, adr_next;
  logic [15:0] wd_reg, wd_next;
  logic [15:0] tog_reg, tog_next; // previous poll sample
  logic ready_next, done_next;
  logic [15:0] rdata_next;
  logic pl1_reg, pl2_reg; // power-low synchroniser
  logic cyc_start, cyc_wr, cyc_done;
  logic [19:0] cyc_addr;
  logic [15:0] cyc_wdata, cyc_rdata;

  fwsp_bus_cycle u_cycle (
    .clk(clk), .rst(rst), .start(cyc_start), .wr(cyc_wr),
    .addr(cyc_addr), .wdata(cyc_wdata), .done(cyc_done),
    .rdata(cyc_rdata), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .a(a), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i)
  );

  // number of write cycles per operation
  function automatic logic [2:0] fwsp_len(input logic [2:0] o);
    case (o)
      FWSP_OP_PROGRAM: fwsp_len = 3'd4; // three unlock + data
      FWSP_OP_SECTOR, FWSP_OP_BLOCK,
      FWSP_OP_CHIP: fwsp_len = 3'd6; // full erase sequence
      FWSP_OP_ID, FWSP_OP_CFI: fwsp_len = 3'd3;
      FWSP_OP_EXIT: fwsp_len = 3'd1;
      default: fwsp_len = 3'd0;
    endcase
  endfunction : fwsp_len

  // address and data of each command cycle, upper byte zero except the program data word
  always_comb begin
    cyc_addr = FWSP_ADDR_UNLOCK1;
    cyc_wdata = {8'h00, FWSP_CODE_UNLOCK1};
    case (step_reg)
      3'd0, 3'd3: begin
        cyc_addr = FWSP_ADDR_UNLOCK1;
        cyc_wdata = {8'h00, FWSP_CODE_UNLOCK1};
      end
      3'd1, 3'd4: begin
        cyc_addr = FWSP_ADDR_UNLOCK2;
        cyc_wdata = {8'h00, FWSP_CODE_UNLOCK2};
      end
      3'd2: begin
        cyc_addr = FWSP_ADDR_UNLOCK1;
        case (op_reg)
          FWSP_OP_PROGRAM: cyc_wdata = {8'h00, FWSP_CODE_PROGRAM};
          FWSP_OP_ID: cyc_wdata = {8'h00, FWSP_CODE_ID_ENTRY};
          FWSP_OP_CFI: cyc_wdata = {8'h00, FWSP_CODE_CFI_ENTRY};
          default: cyc_wdata = {8'h00, FWSP_CODE_ERASE_SETUP};
        endcase
      end
      default: ;
    endcase
    if (op_reg == FWSP_OP_EXIT) begin
      cyc_addr = FWSP_ADDR_UNLOCK1;
      cyc_wdata = {8'h00, FWSP_CODE_EXIT}; // leave ID/query
    end else if (step_reg == 3'd3 && op_reg == FWSP_OP_PROGRAM) begin
      cyc_addr = adr_reg;
      cyc_wdata = wd_reg;
    end else if (step_reg == 3'd5) begin
      case (op_reg)
        FWSP_OP_SECTOR: begin
          cyc_addr = {adr_reg[19:FWSP_SECTOR_LSB], 11'h000};
          cyc_wdata = {8'h00, FWSP_CODE_SECTOR};
        end
        FWSP_OP_BLOCK: begin
          cyc_addr = {adr_reg[19:FWSP_BLOCK_LSB], 15'h0000};
          cyc_wdata = {8'h00, FWSP_CODE_BLOCK};
        end
        default: begin
          cyc_addr = FWSP_ADDR_UNLOCK1;
          cyc_wdata = {8'h00, FWSP_CODE_CHIP};
        end
      endcase
    end
    if (st_reg == FWSP_POLL1 || st_reg == FWSP_POLL2) begin
      cyc_addr = adr_reg;
    end else if (st_reg == FWSP_READ) begin
      cyc_addr = adr_reg;
    end
  end

  // main sequencer next state
  always_comb begin
    st_next = st_reg;
    step_next = step_reg;
    nstep_next = nstep_reg;
    op_next = op_reg;
    adr_next = adr_reg;
    wd_next = wd_reg;
    tog_next = tog_reg;
    ready_next = 1'b0;
    done_next = 1'b0;
    rdata_next = rdata;
    cyc_start = 1'b0;
    cyc_wr = 1'b0;
    case (st_reg)
      FWSP_IDLE: begin
        ready_next = 1'b1;
        if (req) begin
          ready_next = 1'b0;
          op_next = op;
          adr_next = addr;
          wd_next = wdata;
          step_next = 3'd0;
          nstep_next = fwsp_len(op);
          if (op == FWSP_OP_READ) begin
            st_next = FWSP_READ; // array, ID or query word
          end else if (pl2_reg) begin
            st_next = FWSP_FIN; // refuse writes at power low
          end else begin
            st_next = FWSP_CMD; // sequence always sent whole
          end
        end
      end
      FWSP_CMD: begin
        cyc_start = 1'b1;
        cyc_wr = 1'b1;
        if (cyc_done) begin
          cyc_start = 1'b0;
          step_next = step_reg + 3'd1;
          if (step_reg + 3'd1 == nstep_reg) begin
            // status valid after last strobe rise
            if (op_reg == FWSP_OP_PROGRAM || op_reg == FWSP_OP_SECTOR ||
                op_reg == FWSP_OP_BLOCK || op_reg == FWSP_OP_CHIP) begin
              st_next = FWSP_POLL1;
            end else begin
              st_next = FWSP_FIN;
            end
          end
        end
      end
      FWSP_POLL1: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          cyc_start = 1'b0;
          tog_next = cyc_rdata;
          st_next = FWSP_POLL2;
        end
      end
      FWSP_POLL2: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          cyc_start = 1'b0;
          // stable toggle bit means done; else poll on
          if (cyc_rdata[FWSP_TOGGLE_BIT] == tog_reg[FWSP_TOGGLE_BIT]) begin
            rdata_next = cyc_rdata;
            st_next = FWSP_FIN;
          end else begin
            tog_next = cyc_rdata; // no command while busy
          end
        end
      end
      FWSP_READ: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          cyc_start = 1'b0;
          rdata_next = cyc_rdata;
          st_next = FWSP_FIN;
        end
      end
      FWSP_FIN: begin
        done_next = 1'b1;
        st_next = FWSP_IDLE;
      end
      default: st_next = FWSP_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= FWSP_IDLE;
      step_reg <= 3'd0;
      nstep_reg <= 3'd0;
      op_reg <= 3'd0;
      adr_reg <= 20'h00000;
      wd_reg <= 16'h0000;
      tog_reg <= 16'h0000;
      ready <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      pl1_reg <= 1'b0;
      pl2_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      step_reg <= step_next;
      nstep_reg <= nstep_next;
      op_reg <= op_next;
      adr_reg <= adr_next;
      wd_reg <= wd_next;
      tog_reg <= tog_next;
      ready <= ready_next;
      done <= done_next;
      rdata <= rdata_next;
      pl1_reg <= power_low;
      pl2_reg <= pl1_reg;
    end
  end

  sequence s_write_strobe;
    $fell(we_n);
  endsequence
  a_power_block: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_IDLE && req && op != FWSP_OP_READ && pl2_reg)
    |=> st_reg == FWSP_FIN)
    else $error("write started at power low");
  a_inhibit_write: assert property (@(posedge clk) disable iff (rst)
    s_write_strobe |-> !ce_n && oe_n)
    else $error("write strobe without select or with gate low");
  a_upper_byte: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && !(op_reg == FWSP_OP_PROGRAM && step_reg == 3'd3))
    |-> cyc_wdata[15:8] == 8'h00)
    else $error("command upper byte not zero");
  a_cfi_code: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && op_reg == FWSP_OP_CFI && step_reg == 3'd2)
    |-> cyc_addr == FWSP_ADDR_UNLOCK1 && cyc_wdata[7:0] == 8'h98)
    else $error("query entry code wrong");
  a_erase_len: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && $past(st_reg) == FWSP_IDLE &&
     op_reg == FWSP_OP_CHIP) |-> nstep_reg == 3'd6)
    else $error("erase sequence not six cycles");
  a_prog_len: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && op_reg == FWSP_OP_PROGRAM)
    |-> nstep_reg == 3'd4)
    else $error("program sequence not four cycles");
  a_poll_follows: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && cyc_done && step_reg + 3'd1 == nstep_reg &&
     op_reg == FWSP_OP_SECTOR) |=> st_reg == FWSP_POLL1)
    else $error("no status poll after erase");
  a_sector_addr: assert property (@(posedge clk) disable iff (rst)
    (st_reg == FWSP_CMD && op_reg == FWSP_OP_SECTOR && step_reg == 3'd5)
    |-> cyc_addr[10:0] == 11'h000)
    else $error("sector address low bits set");
endmodule : fwsp_host

// >>> dv/fwsp_flash_model.sv
`timescale 1ns/10ps
// behavioural flash device on the far side of the host
module fwsp_flash_model
  import fwsp_pkg::*;
#(
  parameter int PROG_NS = 600, // busy span of a word program
  parameter int ERASE_NS = 3000, // busy span of any erase
  parameter logic [15:0] MFR_CODE = 16'h1A2B, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h3C4D // arbitrary value
)
(
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] a,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int]; // written words, absent means erased
  logic [19:0] wa; // address of the current write pulse
  logic [19:0] pa; // target of the running operation
  logic [15:0] pd; // data or erase code of the running operation
  logic [15:0] last = 16'h0000; // last word driven
  int step = 0; // position in the unlock sequence
  int mode = 0; // 0 array, 1 identification, 2 query
  int sh; // address shift that selects the erase span
  int kq[$]; // keys to drop on erase
  bit erase_seq = 0;
  bit busy = 0;
  bit erasing = 0;
  bit tgl = 1;
  realtime t_on; // start of the write pulse
  wire wr = !ce_n && !we_n && oe_n;
  wire rd = !ce_n && !oe_n;
  // word returned by a read in the present state
  function automatic logic [15:0] rdval(input logic [19:0] ad);
    if (busy) return {8'h00, erasing ? 1'b0 : ~pd[7], tgl, 6'h00};
    if (mode == 1) return ad[0] ? DEV_CODE : MFR_CODE;
    if (mode == 2) return (ad == 20'h00010) ? 16'h0051 : 16'h0000;
    return mem.exists(ad) ? mem[ad] : 16'hFFFF;
  endfunction : rdval
  // drive when selected and gated, else show a changed word
  always @(rd or a or busy or tgl or mode or last) begin
    if (rd) dq_out = rdval(a);
    else dq_out = ~last;
  end
  // end of a read: remember the word, advance the toggle while busy
  always @(negedge rd) begin
    last = rdval(a);
    if (busy) tgl = ~tgl;
  end
  // address on the later falling strobe
  always @(posedge wr) begin
    t_on = $realtime;
    wa = a;
  end
  // data on the earlier rising strobe, short pulses dropped
  always @(negedge wr) begin
    if ($realtime - t_on >= FWSP_GLITCH_NS && !busy) cmd(wa, dq_in);
  end
  // start an internal operation
  task automatic start(input int n, input bit e);
    busy = 1;
    erasing = e;
    tgl = 1;
    sh = n;
  endtask : start
  // command decoder, upper data byte unused except in the program data word
  task automatic cmd(input logic [19:0] ad, input logic [15:0] d);
    logic [14:0] c;
    logic [7:0] b;
    c = ad[14:0];
    b = d[7:0];
    if (b == FWSP_CODE_EXIT && !(step == 3 && !erase_seq)) begin
      mode = 0;
      step = 0;
    end else case (step)
      0: step = (c == FWSP_ADDR_UNLOCK1[14:0] && b == 8'hAA) ? 1 : 0;
      1, 4: step = (c == FWSP_ADDR_UNLOCK2[14:0] && b == 8'h55) ? step + 1 : 0;
      2: begin
        step = 0;
        if (c == FWSP_ADDR_UNLOCK1[14:0]) case (b)
          FWSP_CODE_PROGRAM: begin step = 3; erase_seq = 0; end
          FWSP_CODE_ERASE_SETUP: begin step = 3; erase_seq = 1; end
          FWSP_CODE_ID_ENTRY: mode = 1;
          FWSP_CODE_CFI_ENTRY: mode = 2;
          default: ;
        endcase
      end
      3: begin
        step = 0;
        if (erase_seq) step = (c == FWSP_ADDR_UNLOCK1[14:0] && b == 8'hAA) ? 4 : 0;
        else begin pa = ad; pd = d; start(PROG_NS, 0); end
      end
      default: begin
        step = 0;
        if (b == FWSP_CODE_SECTOR || b == FWSP_CODE_BLOCK ||
            (b == FWSP_CODE_CHIP && c == FWSP_ADDR_UNLOCK1[14:0])) begin
          pa = ad;
          pd = {8'h00, b};
          start(ERASE_NS, 1);
        end
      end
    endcase
  endtask : cmd
  // busy span, then the array changes
  always @(posedge busy) begin
    #(sh);
    if (!erasing) mem[pa] = pd & (mem.exists(pa) ? mem[pa] : 16'hFFFF);
    else begin
      sh = (pd[7:0] == FWSP_CODE_SECTOR) ? FWSP_SECTOR_LSB : (pd[7:0] == FWSP_CODE_BLOCK) ? FWSP_BLOCK_LSB : 20;
      kq.delete();
      foreach (mem[k]) if ((k >> sh) == (int'(pa) >> sh)) kq.push_back(k);
      foreach (kq[i]) mem.delete(kq[i]);
    end
    busy = 0;
  end
endmodule : fwsp_flash_model

// >>> dv/flash_write_status_and_protection_tb.sv
`timescale 1ns/10ps
// host sequencer against the device model
module flash_write_status_and_protection_tb
  import fwsp_pkg::*;
;
  localparam logic [15:0] MFR = 16'h1A2B; // arbitrary value
  localparam logic [15:0] DEV = 16'h3C4D; // arbitrary value
  localparam logic [35:0] W1 = {20'h05555, 16'h00AA};
  localparam logic [35:0] W2 = {20'h02AAA, 16'h0055};
  logic clk = 0, rst = 1, req = 0, power_low = 0;
  logic [2:0] op = 0;
  logic [19:0] addr = 0, a;
  logic [15:0] wdata = 0, rdata, dq_o, fl_q, dq_i, rd_cur;
  logic ready, done, ce_n, oe_n, we_n, dq_oe;
  logic [35:0] wq[$]; // writes seen on the pins
  logic [15:0] rq[$]; // words of finished reads
  bit rd_on = 0;
  int err_count = 0, n_tests = 0;
  // clock and bus resolution
  always #10 clk = ~clk;
  assign dq_i = dq_oe ? dq_o : fl_q;
  fwsp_host i_dut(.clk(clk), .rst(rst), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .power_low(power_low), .ready(ready), .done(done),
    .rdata(rdata), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(a),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  fwsp_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_flash(.ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .a(a), .dq_in(dq_i), .dq_out(fl_q));
  // log each write at its strobe rise
  always @(posedge we_n) if (!ce_n) wq.push_back({a, dq_o});
  // log the word of each read
  always @(negedge clk) begin
    if (!ce_n && !oe_n) begin rd_cur = dq_i; rd_on = 1; end
    else if (rd_on) begin rq.push_back(rd_cur); rd_on = 0; end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one user operation, bounded waits
  task automatic run(input logic [2:0] o, input logic [19:0] ad,
    input logic [15:0] d);
    int n;
    n = 0;
    wq.delete();
    rq.delete();
    while (ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    if (n >= 100) check(0, 1);
    op = o;
    addr = ad;
    wdata = d;
    req = 1;
    @(negedge clk);
    req = 0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    if (n >= 2000) check(0, 1);
  endtask : run
  task automatic rd_chk(input logic [19:0] ad, input logic [15:0] exp);
    run(FWSP_OP_READ, ad, 16'h0000);
    check(rdata, exp);
  endtask : rd_chk
  task automatic t_modes();
    run(FWSP_OP_ID, 20'h00000, 16'h0000);
    check(wq[$], {20'h05555, 16'h0090});
    rd_chk(20'h00000, MFR);
    rd_chk(20'h00001, DEV);
    run(FWSP_OP_EXIT, 20'h00000, 16'h0000);
    rd_chk(20'h00001, 16'hFFFF);
    run(FWSP_OP_CFI, 20'h00000, 16'h0000);
    check(wq[$], {20'h05555, 16'h0098});
    rd_chk(20'h00010, 16'h0051);
    run(FWSP_OP_EXIT, 20'h00000, 16'h0000);
    rd_chk(20'h00010, 16'hFFFF);
  endtask : t_modes
  task automatic t_program(input logic [19:0] ad, input logic [15:0] d);
    logic [35:0] exp[$];
    run(FWSP_OP_PROGRAM, ad, d);
    exp = '{W1, W2, {20'h05555, 16'h00A0}, {ad, d}};
    check(wq.size(), 4);
    foreach (exp[i]) check(wq[i], exp[i]);
    check(rq[0][7:6], {~d[7], 1'b1});
    check(rq[1][6], 1'b0);
    check(rq[$], d);
    check(rdata, d);
    rd_chk(ad, d);
  endtask : t_program
  task automatic t_erase(input logic [2:0] o, input logic [35:0] lw,
    input logic [19:0] ad, input logic [15:0] v);
    logic [35:0] exp[$];
    run(o, lw[35:16], 16'h0000);
    exp = '{W1, W2, {20'h05555, 16'h0080}, W1, W2, lw};
    check(wq.size(), 6);
    foreach (exp[i]) check(wq[i], exp[i]);
    check(rq[0][7:6], 2'b01);
    check(rq[$][7], 1'b1);
    check(rdata[7], 1'b1);
    rd_chk(ad, v);
  endtask : t_erase
  task automatic t_power();
    power_low = 1;
    repeat (4) @(negedge clk);
    run(FWSP_OP_PROGRAM, 20'h00200, 16'h0000);
    check(wq.size(), 0);
    power_low = 0;
    repeat (4) @(negedge clk);
    rd_chk(20'h00200, 16'hFFFF);
  endtask : t_power
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_modes();
    t_program(20'h00123, 16'h1234);
    t_program(20'h00801, 16'h80FF);
    t_erase(FWSP_OP_SECTOR, {20'h00800, 16'h0030}, 20'h00801, 16'hFFFF);
    rd_chk(20'h00123, 16'h1234);
    t_erase(FWSP_OP_BLOCK, {20'h08000, 16'h0050}, 20'h00123, 16'h1234);
    t_erase(FWSP_OP_CHIP, {20'h05555, 16'h0010}, 20'h00123, 16'hFFFF);
    t_power();
    end_sim();
  end
  // watchdog well past the expected run
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule : flash_write_status_and_protection_tb
